// >>> common/serial_port_defines.vh
// Constants for the asynchronous serial port: field positions, reset values, counts.
// Included by bare name from every design file of the port.
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// Control register bit positions
`define CTL_MODULE_EN 0
`define CTL_HSE 5
`define CTL_EOT 4
`define CTL_TXE 8
`define CTL_RXE 9
`define CTL_RESET 10'h300

// Line settings fields
`define LCR_PEN 1
`define LCR_EPS 2
`define LCR_STP2 3
`define LCR_WLEN_LO 5
`define LCR_WLEN_HI 6

// Interrupt source bit positions
`define IRQ_RX 4
`define IRQ_TX 5
`define IRQ_RT 6
`define IRQ_FE 7
`define IRQ_PE 8
`define IRQ_BE 9
`define IRQ_OE 10
`define IRQ_W 11

// Receive status bits beside the character
`define RST_FE 8
`define RST_PE 9
`define RST_BE 10
`define RST_OE 11

// Timing counts
`define TICKS_16X 5'h10
`define TICKS_8X 5'h08
`define TIMEOUT_BITS 6'h20
`define FIFO_DEPTH 16

`endif

// >>> rtl/serial_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may coincide.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_defines.vh"
module serial_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = 4
)
(
    input wire clk_i,
    input wire reset_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    output wire [AW:0] level_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_q != DEPTH);
    assign out_valid_o = (cnt_q != 0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem_q[rd_q];
    assign level_o = cnt_q;
    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
        if (reset_i)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop & ~push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/serial_baud_gen.v
// Fractional baud generator: one-cycle tick at 16x or 8x the baud rate.
// Divisor is integer plus sixty-fourths; zero integer part halts ticks.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_defines.vh"
module serial_baud_gen (
    input wire clk_i,
    input wire reset_i,
    input wire run_i,
    input wire [15:0] div_int_i,
    input wire [5:0] div_frac_i,
    output reg tick_o
);
    // Count in 1/64 system clocks so the fraction accumulates exactly
    reg [21:0] acc_q;
    wire [21:0] step;
    wire [21:0] div_full;
    assign div_full = {div_int_i, div_frac_i};
    assign step = 22'h000040;
    always @(posedge clk_i)
    begin
        if (reset_i | ~run_i | (div_int_i == 16'h0000))
        begin
            acc_q <= 22'h000000;
            tick_o <= 1'b0;
        end
        else if (acc_q + step >= div_full)
        begin
            acc_q <= acc_q + step - div_full;
            tick_o <= 1'b1;
        end
        else
        begin
            acc_q <= acc_q + step;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/serial_port.v
// Asynchronous serial port: transmitter, receiver, 16-entry FIFOs, interrupts.
// Assumes inputs synchronous to clk_i; control bits arrive as plain ports.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_defines.vh"
module serial_port #(
    parameter DEPTH = `FIFO_DEPTH
)
(
    input wire clk_i,
    input wire reset_i,
    input wire [9:0] ctl_wdata_i,
    input wire ctl_we_i,
    input wire [15:0] integer_divisor_i,
    input wire [5:0] fraction_divisor_i,
    input wire [7:0] line_settings_i,
    input wire line_settings_we_i,
    input wire [2:0] transmit_level_select_i,
    input wire [2:0] receive_level_select_i,
    input wire [10:0] source_mask_bits_i,
    input wire [10:0] interrupt_clear_i,
    input wire interrupt_clear_we_i,
    input wire [7:0] tx_data_i,
    input wire tx_valid_i,
    output reg tx_ready_o,
    input wire rx_ready_i,
    output reg rx_valid_o,
    output reg [11:0] rx_data_o,
    input wire serial_receive_input_i,
    output reg serial_transmit_output_o,
    output reg busy_o,
    output reg [10:0] raw_status_o,
    output reg [10:0] masked_status_o,
    output reg irq_o,
    output reg [9:0] ctl_o
);
    localparam TX_IDLE = 4'b0001;
    localparam TX_START = 4'b0010;
    localparam TX_BITS = 4'b0100;
    localparam TX_STOP = 4'b1000;
    localparam RX_IDLE = 4'b0001;
    localparam RX_START = 4'b0010;
    localparam RX_BITS = 4'b0100;
    localparam RX_STOP = 4'b1000;

    reg [9:0] ctl_q;
    reg [29:0] shadow_q;
    wire tick;
    wire high_speed_sampling_select = ctl_q[`CTL_HSE];
    wire en = ctl_q[`CTL_MODULE_EN];
    wire [4:0] ovs = high_speed_sampling_select ? `TICKS_8X : `TICKS_16X;
    wire pen = shadow_q[`LCR_PEN];
    wire eps = shadow_q[`LCR_EPS];
    wire stp2 = shadow_q[`LCR_STP2];
    wire [3:0] nbits = {2'b00, shadow_q[`LCR_WLEN_HI:`LCR_WLEN_LO]} + 4'h5;

    // Control and the 30-bit shadow of divisor plus line settings
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctl_q <= `CTL_RESET;
            shadow_q <= 30'h00000000;
        end
        else
        begin
            if (ctl_we_i)
            begin
                ctl_q <= ctl_wdata_i;
            end
            if (line_settings_we_i)
            begin
                shadow_q <= {integer_divisor_i, fraction_divisor_i, line_settings_i};
            end
        end
    end

    // Stays running while a character is in flight, so disable waits for it
    reg tx_active_q;
    reg rx_active_q;
    serial_baud_gen baud_u (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(en | tx_active_q | rx_active_q),
        .div_int_i(shadow_q[29:14]),
        .div_frac_i(shadow_q[13:8]),
        .tick_o(tick)
    );

    wire txf_ready;
    wire txf_valid;
    wire [7:0] txf_data;
    wire [4:0] txf_level;
    reg txf_pop;
    serial_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(4)) tx_fifo_u (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(txf_ready),
        .in_data_i(tx_data_i),
        .out_valid_o(txf_valid),
        .out_ready_i(txf_pop),
        .out_data_o(txf_data),
        .level_o(txf_level)
    );

    reg [11:0] rx_word;
    reg rxf_push;
    wire rxf_ready;
    wire rxf_valid;
    wire [11:0] rxf_data;
    wire [4:0] rxf_level;
    wire rxf_pop = rxf_valid & rx_ready_i & ~rx_valid_o;
    serial_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(4)) rx_fifo_u (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(rxf_push),
        .in_ready_o(rxf_ready),
        .in_data_i(rx_word),
        .out_valid_o(rxf_valid),
        .out_ready_i(rxf_pop),
        .out_data_o(rxf_data),
        .level_o(rxf_level)
    );

    // Transmitter
    reg [3:0] tx_st_q;
    reg [4:0] tx_tk_q;
    reg [3:0] tx_n_q;
    reg [8:0] tx_sh_q;
    reg tx_par_q;
    reg tx_stop2_q;
    reg tx_done;
    wire tx_bit_end = tick & (tx_tk_q == ovs - 5'h01);
    always @*
    begin
        txf_pop = (tx_st_q == TX_IDLE) & txf_valid & en & ctl_q[`CTL_TXE];
    end
    always @(posedge clk_i)
    begin
        tx_done <= 1'b0;
        if (reset_i)
        begin
            tx_st_q <= TX_IDLE;
            tx_tk_q <= 5'h00;
            tx_n_q <= 4'h0;
            tx_sh_q <= 9'h000;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
            tx_active_q <= 1'b0;
            serial_transmit_output_o <= 1'b1;
        end
        else
        begin
            if (tick)
            begin
                tx_tk_q <= tx_bit_end ? 5'h00 : tx_tk_q + 5'h01;
            end
            case (tx_st_q)
                TX_IDLE:
                begin
                    serial_transmit_output_o <= 1'b1;
                    tx_tk_q <= 5'h00;
                    if (txf_pop)
                    begin
                        tx_sh_q <= {1'b0, txf_data};
                        tx_par_q <= ~eps;
                        tx_n_q <= 4'h0;
                        tx_stop2_q <= stp2;
                        tx_active_q <= 1'b1;
                        tx_st_q <= TX_START;
                        serial_transmit_output_o <= 1'b0;
                    end
                end
                TX_START:
                begin
                    if (tx_bit_end)
                    begin
                        tx_st_q <= TX_BITS;
                        serial_transmit_output_o <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    end
                end
                TX_BITS:
                begin
                    if (tx_bit_end)
                    begin
                        tx_n_q <= tx_n_q + 4'h1;
                        tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                        if (tx_n_q + 4'h1 < nbits)
                        begin
                            serial_transmit_output_o <= tx_sh_q[1];
                            tx_par_q <= tx_par_q ^ tx_sh_q[1];
                        end
                        else if (pen & (tx_n_q + 4'h1 == nbits))
                        begin
                            serial_transmit_output_o <= tx_par_q;
                        end
                        else
                        begin
                            serial_transmit_output_o <= 1'b1;
                            tx_st_q <= TX_STOP;
                        end
                    end
                end
                TX_STOP:
                begin
                    if (tx_bit_end)
                    begin
                        if (tx_stop2_q)
                        begin
                            tx_stop2_q <= 1'b0;
                        end
                        else
                        begin
                            tx_st_q <= TX_IDLE;
                            tx_active_q <= 1'b0;
                            tx_done <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Receiver
    reg [3:0] rx_st_q;
    reg [4:0] rx_tk_q;
    reg [3:0] rx_n_q;
    reg [7:0] rx_sh_q;
    reg rx_par_q;
    reg rx_zero_q;
    reg rx_prev_q;
    reg [5:0] rt_bits_q;
    reg [4:0] rt_tk_q;
    wire [4:0] half = {1'b0, ovs[4:1]};
    wire rx_sample = tick & (rx_tk_q == ovs - 5'h01);
    always @(posedge clk_i)
    begin
        rxf_push <= 1'b0;
        if (reset_i)
        begin
            rx_st_q <= RX_IDLE;
            rx_tk_q <= 5'h00;
            rx_n_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
            rx_zero_q <= 1'b0;
            rx_prev_q <= 1'b1;
            rx_active_q <= 1'b0;
            rx_word <= 12'h000;
        end
        else
        begin
            rx_prev_q <= serial_receive_input_i;
            if (tick)
            begin
                rx_tk_q <= rx_sample ? 5'h00 : rx_tk_q + 5'h01;
            end
            case (rx_st_q)
                RX_IDLE:
                begin
                    rx_tk_q <= 5'h00;
                    if (en & ctl_q[`CTL_RXE] & rx_prev_q & ~serial_receive_input_i)
                    begin
                        rx_st_q <= RX_START;
                        rx_active_q <= 1'b1;
                    end
                end
                RX_START:
                begin
                    if (tick & (rx_tk_q == half - 5'h01))
                    begin
                        rx_tk_q <= 5'h00;
                        if (serial_receive_input_i)
                        begin
                            rx_st_q <= RX_IDLE;
                            rx_active_q <= 1'b0;
                        end
                        else
                        begin
                            rx_st_q <= RX_BITS;
                            rx_n_q <= 4'h0;
                            rx_par_q <= ~eps;
                            rx_zero_q <= 1'b1;
                        end
                    end
                end
                RX_BITS:
                begin
                    if (rx_sample)
                    begin
                        rx_n_q <= rx_n_q + 4'h1;
                        rx_zero_q <= rx_zero_q & ~serial_receive_input_i;
                        rx_par_q <= rx_par_q ^ serial_receive_input_i;
                        if (rx_n_q < nbits)
                        begin
                            rx_sh_q <= {serial_receive_input_i, rx_sh_q[7:1]};
                        end
                        if (rx_n_q + 4'h1 == nbits + {3'b000, pen})
                        begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rx_sample)
                    begin
                        rx_st_q <= RX_IDLE;
                        rx_active_q <= 1'b0;
                        rxf_push <= 1'b1;
                        rx_word <= {~rxf_ready,
                            rx_zero_q & ~serial_receive_input_i,
                            pen & rx_par_q,
                            ~serial_receive_input_i,
                            rx_sh_q >> (4'h8 - nbits)};
                    end
                end
                default:
                begin
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    // Level conditions: select 0..4 is 1/8,1/4,1/2,3/4,7/8 of depth
    function [4:0] lvl;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: lvl = 5'h02;
                3'h1: lvl = 5'h04;
                3'h2: lvl = 5'h08;
                3'h3: lvl = 5'h0C;
                default: lvl = 5'h0E;
            endcase
        end
    endfunction

    wire tx_cond = ctl_q[`CTL_EOT] ? (tx_done & ~txf_valid)
        : (txf_level <= lvl(transmit_level_select_i));
    wire rx_cond = rxf_level >= lvl(receive_level_select_i);
    wire rt_hit = (rt_bits_q == `TIMEOUT_BITS - 6'h01) & tick & (rt_tk_q == ovs - 5'h01);

    // Timeout counter restarts on each received character
    always @(posedge clk_i)
    begin
        if (reset_i | rxf_push | ~rxf_valid)
        begin
            rt_bits_q <= 6'h00;
            rt_tk_q <= 5'h00;
        end
        else if (tick & (rt_bits_q != `TIMEOUT_BITS))
        begin
            rt_tk_q <= (rt_tk_q == ovs - 5'h01) ? 5'h00 : rt_tk_q + 5'h01;
            if (rt_tk_q == ovs - 5'h01)
            begin
                rt_bits_q <= rt_bits_q + 6'h01;
            end
        end
    end

    reg [10:0] set_v;
    reg [10:0] clr_v;
    reg [10:0] raw_d;
    always @*
    begin
        set_v = 11'h000;
        set_v[`IRQ_RX - 4] = 1'b0;
        set_v[`IRQ_RX] = rx_cond;
        set_v[`IRQ_TX] = tx_cond;
        set_v[`IRQ_RT] = rt_hit;
        set_v[`IRQ_FE] = rxf_push & rx_word[`RST_FE];
        set_v[`IRQ_PE] = rxf_push & rx_word[`RST_PE];
        set_v[`IRQ_BE] = rxf_push & rx_word[`RST_BE];
        set_v[`IRQ_OE] = rxf_push & rx_word[`RST_OE];
        clr_v = interrupt_clear_we_i ? interrupt_clear_i : 11'h000;
        clr_v[`IRQ_RT] = clr_v[`IRQ_RT] | ~rxf_valid;
        raw_d = (raw_status_o & ~clr_v) | set_v;
    end

    // Outputs all registered; set wins over a same-cycle clear
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            raw_status_o <= 11'h000;
            masked_status_o <= 11'h000;
            irq_o <= 1'b0;
            busy_o <= 1'b0;
            tx_ready_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 12'h000;
            ctl_o <= `CTL_RESET;
        end
        else
        begin
            raw_status_o <= raw_d;
            masked_status_o <= raw_d & source_mask_bits_i;
            irq_o <= |(raw_d & source_mask_bits_i);
            busy_o <= txf_valid | tx_valid_i | tx_active_q | txf_pop;
            tx_ready_o <= txf_ready & ~(tx_valid_i & (txf_level == DEPTH - 1));
            ctl_o <= ctl_q;
            if (rxf_pop)
            begin
                rx_valid_o <= 1'b1;
                rx_data_o <= rxf_data;
            end
            else if (rx_valid_o & rx_ready_i)
            begin
                rx_valid_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/serial_port_checker.sv
// Checker for the serial port outputs.
// Bound to serial_port; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module serial_port_checker (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic busy_o,
    input wire logic serial_transmit_output_o,
    input wire logic [10:0] raw_status_o,
    input wire logic [10:0] masked_status_o,
    input wire logic [10:0] source_mask_bits_i,
    input wire logic irq_o,
    input wire logic [10:0] interrupt_clear_i,
    input wire logic interrupt_clear_we_i,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [11:0] rx_data_o,
    input wire logic [9:0] ctl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reset_ctl_a: assert property ($fell(reset_i) |-> ctl_o == 10'h300)
        else $error("control not at reset value");
    busy_rise_a: assert property (tx_valid_i && tx_ready_o |-> ##[1:2] busy_o)
        else $error("busy late after push");
    idle_line_a: assert property (!busy_o |-> serial_transmit_output_o)
        else $error("line low while not busy");
    start_len_a: assert property ($fell(serial_transmit_output_o)
        |-> !serial_transmit_output_o [*8])
        else $error("start bit too short");
    masked_and_a: assert property ($stable(raw_status_o) && $stable(source_mask_bits_i)
        |=> ($stable(raw_status_o) && $stable(source_mask_bits_i)
        |-> masked_status_o == (raw_status_o & source_mask_bits_i)))
        else $error("masked status wrong");
    irq_or_a: assert property ($stable(masked_status_o)
        |=> ($stable(masked_status_o) |-> irq_o == |masked_status_o))
        else $error("irq not OR of masked");
    clear_one_a: assert property (interrupt_clear_we_i
        |=> (raw_status_o & $past(interrupt_clear_i) & 11'h780) == 11'h000)
        else $error("clear did not clear");
    clear_zero_a: assert property (interrupt_clear_we_i |=> ($past(raw_status_o)
        & ~$past(interrupt_clear_i) & ~raw_status_o & 11'h780) == 11'h000)
        else $error("zero clear bit cleared");
    rx_hold_a: assert property (rx_valid_o && !rx_ready_i
        |=> rx_valid_o && $stable(rx_data_o))
        else $error("rx word not held");
endmodule
bind serial_port serial_port_checker serial_port_checker_i (.clk_i(clk_i),
    .reset_i(reset_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .busy_o(busy_o),
    .serial_transmit_output_o(serial_transmit_output_o), .raw_status_o(raw_status_o),
    .masked_status_o(masked_status_o), .source_mask_bits_i(source_mask_bits_i),
    .irq_o(irq_o), .interrupt_clear_i(interrupt_clear_i),
    .interrupt_clear_we_i(interrupt_clear_we_i), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .ctl_o(ctl_o));
`default_nettype wire

// >>> tb/serial_line_peer.sv
// Far-end serial device: sends frames, decodes the transmit line.
// Assumes idle-high lines; bench sets the bit period in clocks.
`timescale 1ns/100ps
`default_nettype none
module serial_line_peer (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    int bit_cyc = 32;
    logic [8:0] got[$];
    logic [8:0] sh;
    initial line_o = 1'b1;
    task automatic hold(input logic v, input int n);
        line_o = v;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic send(input logic [7:0] d, input logic pen, input logic p, input logic st);
        hold(1'b0, bit_cyc);
        for (int i = 0; i < 8; i++)
            hold(d[i], bit_cyc);
        if (pen)
            hold(p, bit_cyc);
        hold(st, bit_cyc);
        line_o = 1'b1;
    endtask
    // Mid-bit sampling; no start recheck, the line is trusted
    initial forever
    begin
        @(negedge line_i);
        repeat (bit_cyc / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++)
        begin
            repeat (bit_cyc) @(posedge clk_i);
            sh = {line_i, sh[8:1]};
        end
        got.push_back(sh);
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Bench for the serial port: fill, receive, errors, timeout, fast mode.
// Assumes the peer on both lines; divisor 2 gives 32 clocks a bit.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [9:0] ctl_wdata_i = 10'h000;
    logic ctl_we_i = 1'b0;
    logic [15:0] integer_divisor_i = 16'h0002;
    logic [5:0] fraction_divisor_i = 6'h00;
    logic [7:0] line_settings_i = 8'h60;
    logic line_settings_we_i = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [10:0] source_mask_bits_i = 11'h100;
    logic [10:0] interrupt_clear_i = 11'h000;
    logic interrupt_clear_we_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_valid_i = 1'b0;
    logic rx_ready_i = 1'b0;
    logic tx_ready_o, rx_valid_o, rx_line, tx_line, busy_o, irq_o;
    logic [11:0] rx_data_o;
    logic [10:0] raw_status_o, masked_status_o;
    logic [9:0] ctl_o;
    int err_count = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00000007;
    always #5 clk_i = ~clk_i;
    serial_port serial_port_i (.clk_i(clk_i), .reset_i(reset_i), .ctl_wdata_i(ctl_wdata_i),
        .ctl_we_i(ctl_we_i), .integer_divisor_i(integer_divisor_i),
        .fraction_divisor_i(fraction_divisor_i), .line_settings_i(line_settings_i),
        .line_settings_we_i(line_settings_we_i), .transmit_level_select_i(lvl),
        .receive_level_select_i(lvl), .source_mask_bits_i(source_mask_bits_i),
        .interrupt_clear_i(interrupt_clear_i), .interrupt_clear_we_i(interrupt_clear_we_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
        .serial_receive_input_i(rx_line), .serial_transmit_output_o(tx_line),
        .busy_o(busy_o), .raw_status_o(raw_status_o), .masked_status_o(masked_status_o),
        .irq_o(irq_o), .ctl_o(ctl_o));
    serial_line_peer serial_line_peer_i (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [11:0] exp_rx(input logic [7:0] d, input logic pe, input logic fe);
        return {2'b00, pe, fe, d};
    endfunction
    task check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task wr_ctl(input logic [9:0] v);
        ctl_wdata_i = v;
        ctl_we_i = 1'b1;
        step(1);
        ctl_we_i = 1'b0;
    endtask
    // Settings only change with the port disabled
    task reconfig(input logic [7:0] l, input logic [9:0] c);
        wr_ctl(c & 10'h3FE);
        line_settings_i = l;
        line_settings_we_i = 1'b1;
        step(1);
        line_settings_we_i = 1'b0;
        wr_ctl(c);
    endtask
    // Watches the live signal: 0 busy, 1 transmit line, 2 receive valid
    task wait_for(input int sel, input logic v, input int lim);
        int n;
        n = 0;
        while (n < lim && ((sel == 0) ? busy_o : ((sel == 1) ? tx_line : rx_valid_o)) !== v)
        begin
            step(1);
            n++;
        end
        if (n >= lim)
        begin
            err_count++;
            $display("BAD %0t wait limit reached", $time);
        end
    endtask
    // Output stage loads only while ready is high, so raise it first
    task take_rx(input logic [11:0] e);
        rx_ready_i = 1'b1;
        wait_for(2, 1'b1, 2000);
        check(rx_data_o, e);
        step(1);
        rx_ready_i = 1'b0;
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #400000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop;
    end
    initial
    begin
        logic [7:0] q[$];
        logic [7:0] d;
        step(2);
        reset_i = 1'b0;
        check({2'b00, ctl_o}, 12'h300);
        check({busy_o, tx_line}, 12'h001);
        reconfig(8'h60, 10'h300);
        integer_divisor_i = 16'h0005;
        repeat (20)
        begin
            d = rnd();
            tx_data_i = d;
            tx_valid_i = 1'b1;
            if (tx_ready_o === 1'b1)
                q.push_back(d);
            step(1);
        end
        tx_valid_i = 1'b0;
        check(q.size(), 12'h010);
        check(busy_o, 12'h001);
        wr_ctl(10'h301);
        wait_for(0, 1'b0, 9000);
        foreach (q[i])
            check({3'h0, serial_line_peer_i.got.pop_front()}, {4'h1, q[i]});
        integer_divisor_i = 16'h0002;
        $display("test fill done");
        d = rnd();
        serial_line_peer_i.send(d, 1'b0, 1'b0, 1'b1);
        step(40);
        take_rx(exp_rx(d, 1'b0, 1'b0));
        $display("test receive done");
        reconfig(8'h66, 10'h301);
        for (int k = 0; k < 2; k++)
        begin
            d = rnd();
            serial_line_peer_i.send(d, 1'b1, ^d ^ k[0], 1'b1);
            take_rx(exp_rx(d, k[0], 1'b0));
            check(raw_status_o[8], k);
        end
        check(irq_o, 12'h001);
        interrupt_clear_i = 11'h100;
        interrupt_clear_we_i = 1'b1;
        step(1);
        interrupt_clear_we_i = 1'b0;
        step(2);
        check({raw_status_o[8], irq_o}, 12'h000);
        d = rnd() | 8'h01;
        serial_line_peer_i.send(d, 1'b1, ^d, 1'b0);
        take_rx(exp_rx(d, 1'b0, 1'b1));
        check(raw_status_o[7], 12'h001);
        $display("test errors done");
        serial_line_peer_i.hold(1'b0, 8);
        serial_line_peer_i.hold(1'b1, 400);
        check(rx_valid_o, 12'h000);
        d = rnd();
        serial_line_peer_i.send(d, 1'b1, ^d, 1'b1);
        step(900);
        check(raw_status_o[6], 12'h000);
        step(300);
        check(raw_status_o[6], 12'h001);
        take_rx(exp_rx(d, 1'b0, 1'b0));
        step(2);
        check(raw_status_o[6], 12'h000);
        $display("test timeout done");
        reconfig(8'h60, 10'h331);
        interrupt_clear_i = 11'h020;
        interrupt_clear_we_i = 1'b1;
        step(1);
        interrupt_clear_we_i = 1'b0;
        serial_line_peer_i.bit_cyc = 16;
        d = rnd();
        tx_data_i = d;
        tx_valid_i = 1'b1;
        step(1);
        tx_valid_i = 1'b0;
        wait_for(1, 1'b0, 100);
        wr_ctl(10'h330);
        check(raw_status_o[5], 12'h000);
        wait_for(0, 1'b0, 2000);
        check(raw_status_o[5], 12'h001);
        check({3'h0, serial_line_peer_i.got.pop_front()}, {4'h1, d});
        $display("test fast mode done");
        report_and_stop;
    end
endmodule
`default_nettype wire
